// ### hdl/acp_pkg.sv
`default_nettype none
package acp_pkg;

  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;
  localparam int CNT_W  = 2;
  localparam int INT_W  = 6;
  localparam int UNIT_W = 11;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_ALARM_CODE = 8'hfd;
  localparam logic [ADDR_W-1:0] ADDR_MIN_CYC    = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_INT_STAT   = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_INT_MASK   = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_LAST_SCAN  = 8'h04;

  // Alarm code word fields
  localparam int ALM_CODE_LSB = 0;
  localparam int ALM_WARN_BIT = 8;
  localparam int ALM_HALT_BIT = 9;
  localparam int ALM_CNT_LSB  = 10;

  // Interrupt status and mask bits
  localparam int INT_WARN    = 0;
  localparam int INT_SEVERE  = 1;
  localparam int INT_SYS     = 2;
  localparam int INT_OVERRUN = 3;
  localparam int INT_ERR     = 4;
  localparam int INT_DROP    = 5;

  localparam int CTRL_CLEAR_BIT = 0;

  // Values after reset
  localparam logic [DATA_W-1:0] MIN_CYC_RST = 16'h0000;
  localparam logic [INT_W-1:0]  MASK_RST    = 6'h00;
  localparam logic [CODE_W-1:0] NO_CODE     = 8'h00;

  // Pending code queue
  localparam logic [CNT_W-1:0] QUEUE_DEPTH = 2'h3;

  // Scan pacing: one setting unit is 100 us
  localparam int CLK_HZ      = 20_000_000;
  localparam int UNIT_US     = 100;
  localparam int UNIT_CYCLES = (CLK_HZ / 1_000_000) * UNIT_US;
  localparam logic [UNIT_W-1:0] UNIT_LAST = UNIT_W'(UNIT_CYCLES - 1);
  localparam logic [UNIT_W-1:0] UNITS_SAT = 11'h7ff;

  typedef enum logic [1:0] {
    ACP_KIND_FAL,
    ACP_KIND_FALS,
    ACP_KIND_SCAN
  } acp_kind_t;

  typedef struct packed {
    logic              valid;
    acp_kind_t         kind;
    logic [CODE_W-1:0] definer;
    logic [DATA_W-1:0] operand;
    logic              indirect;
    logic [DATA_W-1:0] pointer;
    logic              in_range;
  } acp_instr_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } acp_bus_req_t;

endpackage
`default_nettype wire

// ### hdl/acp_code_queue.sv
`default_nettype none
module acp_code_queue
  import acp_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              push_in,
  input  wire logic [CODE_W-1:0] push_code_in,
  input  wire logic              pop_in,
  input  wire logic              flush_in,
  output logic      [CODE_W-1:0] head_out,
  output logic      [CNT_W-1:0]  count_out,
  output logic                   accept_out
);

  logic [CODE_W-1:0] slot_q [int'(QUEUE_DEPTH)];
  logic [CODE_W-1:0] slot_d [int'(QUEUE_DEPTH)];
  logic [CNT_W-1:0]  count_q;
  logic [CNT_W-1:0]  count_d;
  logic [CNT_W-1:0]  wr_idx;
  logic              eff_pop;
  logic              eff_push;

  // A pop on an empty queue is harmless and does nothing
  assign eff_pop  = pop_in && (count_q != 2'h0);
  // When full, the newest code is lost so the oldest stay visible
  assign eff_push = push_in && ((count_q != QUEUE_DEPTH) || eff_pop);
  assign wr_idx   = eff_pop ? count_q - 2'h1 : count_q;
  assign count_d  = flush_in ? 2'h0
                  : count_q + CNT_W'(eff_push) - CNT_W'(eff_pop);

  for (genvar i = 0; i < int'(QUEUE_DEPTH); i++)
  begin : g_slot
    logic [CODE_W-1:0] kept;
    if (i == int'(QUEUE_DEPTH) - 1)
    begin : g_last
      assign kept = eff_pop ? NO_CODE : slot_q[i];
    end
    else
    begin : g_mid
      assign kept = eff_pop ? slot_q[i+1] : slot_q[i];
    end
    assign slot_d[i] = flush_in ? NO_CODE
                     : (eff_push && wr_idx == CNT_W'(i)) ? push_code_in
                     : kept;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      slot_q  <= '{default: NO_CODE};
      count_q <= 2'h0;
    end
    else
    begin
      slot_q  <= slot_d;
      count_q <= count_d;
    end
  end

  assign head_out   = slot_q[0];
  assign count_out  = count_q;
  assign accept_out = eff_push;

endmodule
`default_nettype wire

// ### hdl/acp_top.sv
// Chosen here: the strobed register port.
`default_nettype none
module acp_top
  import acp_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_n_in,
  input  wire acp_bus_req_t      bus_in,
  output logic      [DATA_W-1:0] bus_rdata_out,
  input  wire acp_instr_t        instr_in,
  input  wire logic              sys_err_valid_in,
  input  wire logic [CODE_W-1:0] sys_err_code_in,
  input  wire logic              scan_end_in,
  output logic                   scan_start_out,
  output logic                   warn_led_out,
  output logic                   alarm_led_out,
  output logic                   halt_out,
  output logic                   msg_clear_out,
  output logic                   error_flag_out,
  output logic                   irq_out
);

  typedef enum logic [1:0] {
    ACP_RUN,
    ACP_WAIT,
    ACP_STOP
  } acp_pace_t;

  function automatic logic is_bcd(input logic [DATA_W-1:0] w);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ok = ok && (w[4*k +: 4] <= 4'h9);
    end
    return ok;
  endfunction

  // Only the three low digits count
  function automatic logic [UNIT_W-1:0] bcd3_to_bin(
    input logic [DATA_W-1:0] w);
    logic [UNIT_W-1:0] v;
    v = UNIT_W'(w[11:8]) * 11'h064
      + UNIT_W'(w[7:4]) * 11'h00a
      + UNIT_W'(w[3:0]);
    return v;
  endfunction

  logic              halt_q;
  logic              halt_d;
  logic              warn_q;
  logic              warn_d;
  logic              msg_clear_q;
  logic              error_flag_q;
  logic [DATA_W-1:0] min_cyc_q;
  logic [DATA_W-1:0] min_cyc_d;
  logic [INT_W-1:0]  stat_q;
  logic [INT_W-1:0]  stat_d;
  logic [INT_W-1:0]  mask_q;
  logic [INT_W-1:0]  events;
  logic [UNIT_W-1:0] pre_q;
  logic [UNIT_W-1:0] elapsed_q;
  logic [UNIT_W-1:0] last_scan_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              scan_start_q;
  logic              scan_start_d;
  acp_pace_t         pace_q;
  acp_pace_t         pace_d;
  logic              overrun;

  // Instruction decode
  wire logic accepted  = instr_in.valid && !halt_q;
  wire logic fal_hit   = accepted && instr_in.kind == ACP_KIND_FAL;
  wire logic fals_hit  = accepted && instr_in.kind == ACP_KIND_FALS;
  wire logic scan_hit  = accepted && instr_in.kind == ACP_KIND_SCAN;
  wire logic def_zero  = instr_in.definer == NO_CODE;
  wire logic def_ok    = is_bcd({8'h00, instr_in.definer}) && !def_zero;
  wire logic fal_post  = fal_hit && def_ok;
  wire logic fals_post = fals_hit && def_ok;
  wire logic fal_reset = fal_hit && def_zero;
  wire logic def_bad   = (fal_hit && !def_ok && !def_zero)
                      || (fals_hit && !def_ok);
  wire logic scan_bad  = scan_hit && instr_in.indirect
                      && (!is_bcd(instr_in.pointer)
                          || !instr_in.in_range);
  wire logic scan_load = scan_hit && !scan_bad;

  // Register port decode
  wire logic wr_min   = bus_in.wr && bus_in.addr == ADDR_MIN_CYC;
  wire logic wr_stat  = bus_in.wr && bus_in.addr == ADDR_INT_STAT;
  wire logic wr_mask  = bus_in.wr && bus_in.addr == ADDR_INT_MASK;
  wire logic wr_ctrl  = bus_in.wr && bus_in.addr == ADDR_CONTROL;
  wire logic clear_rq = wr_ctrl && bus_in.wdata[CTRL_CLEAR_BIT];

  // Queue feed: internal errors win a shared cycle
  wire logic              user_post = fal_post || fals_post;
  wire logic              push      = sys_err_valid_in || user_post;
  wire logic [CODE_W-1:0] push_code = sys_err_valid_in ? sys_err_code_in
                                    : instr_in.definer;
  logic [CODE_W-1:0] head;
  logic [CNT_W-1:0]  q_count;
  logic              q_accept;

  acp_code_queue u_queue (
    .sys_clk_in   (sys_clk_in),
    .rst_n_in     (rst_n_in),
    .push_in      (push && !clear_rq),
    .push_code_in (push_code),
    .pop_in       (fal_reset),
    .flush_in     (clear_rq),
    .head_out     (head),
    .count_out    (q_count),
    .accept_out   (q_accept)
  );

  wire logic dropped = (push && !clear_rq && !q_accept)
                    || (sys_err_valid_in && user_post);
  wire logic queue_empties = fal_reset && q_count <= 2'h1 && !push;

  // Warning stays lit until the area is empty or cleared; a post wins
  assign warn_d = fal_post
               || (warn_q && !clear_rq && !queue_empties);
  // Only the console clear releases a halt
  assign halt_d = fals_post || (halt_q && !clear_rq);

  // Setting: instruction has priority over a same-cycle port write
  assign min_cyc_d = scan_load ? instr_in.operand
                   : (wr_min && is_bcd(bus_in.wdata)) ? bus_in.wdata
                   : min_cyc_q;
  wire logic [UNIT_W-1:0] set_units = bcd3_to_bin(min_cyc_q);
  wire logic              time_met  = elapsed_q >= set_units;

  // Scan pacing
  always_comb
  begin
    pace_d       = pace_q;
    scan_start_d = 1'b0;
    overrun      = 1'b0;
    case (pace_q)
      ACP_RUN:
      begin
        if (scan_end_in)
        begin
          if (halt_d)
          begin
            pace_d = ACP_STOP;
          end
          else if (time_met)
          begin
            scan_start_d = 1'b1;
            overrun      = elapsed_q > set_units;
          end
          else
          begin
            pace_d = ACP_WAIT;
          end
        end
      end
      ACP_WAIT:
      begin
        if (halt_d)
        begin
          pace_d = ACP_STOP;
        end
        else if (time_met)
        begin
          scan_start_d = 1'b1;
          pace_d       = ACP_RUN;
        end
      end
      ACP_STOP:
      begin
        if (!halt_d)
        begin
          scan_start_d = 1'b1;
          pace_d       = ACP_RUN;
        end
      end
      default:
      begin
        pace_d = ACP_STOP;
      end
    endcase
  end

  // Interrupt status: a new event beats a same-cycle clear
  assign events[INT_WARN]    = fal_post;
  assign events[INT_SEVERE]  = fals_post;
  assign events[INT_SYS]     = sys_err_valid_in;
  assign events[INT_OVERRUN] = overrun;
  assign events[INT_ERR]     = def_bad || scan_bad;
  assign events[INT_DROP]    = dropped;
  assign stat_d = (stat_q & ~(wr_stat ? bus_in.wdata[INT_W-1:0]
                                      : {INT_W{1'b0}})) | events;

  wire logic [DATA_W-1:0] alarm_word =
    DATA_W'({q_count, halt_q, warn_q, head});

  always_comb
  begin
    rdata_d = 16'h0000;
    if (bus_in.rd)
    begin
      case (bus_in.addr)
        ADDR_ALARM_CODE: rdata_d = alarm_word;
        ADDR_MIN_CYC:    rdata_d = min_cyc_q;
        ADDR_INT_STAT:   rdata_d = DATA_W'(stat_q);
        ADDR_INT_MASK:   rdata_d = DATA_W'(mask_q);
        ADDR_LAST_SCAN:  rdata_d = DATA_W'(last_scan_q);
        default:         rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      halt_q       <= 1'b0;
      warn_q       <= 1'b0;
      msg_clear_q  <= 1'b0;
      error_flag_q <= 1'b0;
      min_cyc_q    <= MIN_CYC_RST;
      stat_q       <= '0;
      mask_q       <= MASK_RST;
      rdata_q      <= 16'h0000;
      pace_q       <= ACP_STOP;
      scan_start_q <= 1'b0;
    end
    else
    begin
      halt_q       <= halt_d;
      warn_q       <= warn_d;
      msg_clear_q  <= fal_reset;
      min_cyc_q    <= min_cyc_d;
      stat_q       <= stat_d;
      mask_q       <= wr_mask ? bus_in.wdata[INT_W-1:0] : mask_q;
      rdata_q      <= rdata_d;
      pace_q       <= pace_d;
      scan_start_q <= scan_start_d;
      if (accepted)
      begin
        error_flag_q <= def_bad || scan_bad;
      end
    end
  end

  // Elapsed time since the last scan start, in setting units
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pre_q       <= '0;
      elapsed_q   <= '0;
      last_scan_q <= '0;
    end
    else
    begin
      if (scan_start_d)
      begin
        pre_q     <= '0;
        elapsed_q <= '0;
      end
      else if (pre_q == UNIT_LAST)
      begin
        pre_q     <= '0;
        elapsed_q <= (elapsed_q == UNITS_SAT) ? elapsed_q
                                              : elapsed_q + 11'h001;
      end
      else
      begin
        pre_q <= pre_q + 11'h001;
      end
      if (scan_end_in && pace_q == ACP_RUN)
      begin
        last_scan_q <= elapsed_q;
      end
    end
  end

  assign bus_rdata_out  = rdata_q;
  assign scan_start_out = scan_start_q;
  assign warn_led_out   = warn_q;
  assign alarm_led_out  = halt_q;
  assign halt_out       = halt_q;
  assign msg_clear_out  = msg_clear_q;
  assign error_flag_out = error_flag_q;
  // Level output: stays high until software clears or masks the bits
  assign irq_out        = |(stat_q & mask_q);

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  property p_user_code_shown;
    fal_post && q_count == 2'h0 && !sys_err_valid_in && !clear_rq
      |=> head == $past(instr_in.definer);
  endproperty
  a_user_code_shown: assert property (p_user_code_shown)
    else $error("posted alarm code not shown");

  property p_bad_definer;
    fals_hit && !def_ok |=> error_flag_out && !halt_out;
  endproperty
  a_bad_definer: assert property (p_bad_definer)
    else $error("non-BCD definer not refused");

  property p_reset_pops;
    fal_reset && q_count != 2'h0 && !push && !clear_rq
      |=> q_count == $past(q_count) - 2'h1 ##0 msg_clear_out;
  endproperty
  a_reset_pops: assert property (p_reset_pops)
    else $error("reset form did not advance queue");

  property p_warn_runs;
    fal_post && !clear_rq && !halt_q |=> warn_led_out && !halt_out;
  endproperty
  a_warn_runs: assert property (p_warn_runs)
    else $error("non-fatal alarm handling wrong");

  property p_severe_halts;
    fals_post |=> (alarm_led_out && !scan_start_out) [*2];
  endproperty
  a_severe_halts: assert property (p_severe_halts)
    else $error("severe alarm did not halt");

  property p_sys_code_shown;
    sys_err_valid_in && q_count == 2'h0 && !clear_rq
      |=> head == $past(sys_err_code_in);
  endproperty
  a_sys_code_shown: assert property (p_sys_code_shown)
    else $error("internal code not posted");

  property p_depth;
    q_count <= QUEUE_DEPTH;
  endproperty
  a_depth: assert property (p_depth)
    else $error("pending queue exceeds three");

  property p_short_waits;
    pace_q == ACP_RUN && scan_end_in && !halt_d && !time_met
      |=> !scan_start_out && pace_q == ACP_WAIT;
  endproperty
  a_short_waits: assert property (p_short_waits)
    else $error("short scan not held");

  property p_long_runs;
    pace_q == ACP_RUN && scan_end_in && !halt_d && time_met
      |=> scan_start_out ##1 !scan_start_out;
  endproperty
  a_long_runs: assert property (p_long_runs)
    else $error("long scan delayed");

  property p_bad_indirect;
    scan_bad && !wr_min |=> error_flag_out && min_cyc_q == $past(min_cyc_q);
  endproperty
  a_bad_indirect: assert property (p_bad_indirect)
    else $error("bad indirect operand accepted");

  property p_setting_load;
    scan_load && !clear_rq |=> min_cyc_q == $past(instr_in.operand);
  endproperty
  a_setting_load: assert property (p_setting_load)
    else $error("cycle setting not loaded");

  property p_top_digit;
    is_bcd(min_cyc_q) |-> set_units <= 11'h3e7;
  endproperty
  a_top_digit: assert property (p_top_digit)
    else $error("top digit counted");

endmodule
`default_nettype wire

// ### test/acp_scan_model.sv
`default_nettype none
module acp_scan_model
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        scan_start_in,
  input  wire logic [15:0] scan_len_in,
  output logic             scan_end_out
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] left_q;
  logic        busy_q;

  // One program scan ends scan_len_in + 1 cycles after each start pulse is sampled
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      busy_q       <= 1'b0;
      left_q       <= 16'h0000;
      scan_end_out <= 1'b0;
    end
    else
    begin
      scan_end_out <= 1'b0;
      if (scan_start_in)
      begin
        busy_q <= 1'b1;
        left_q <= scan_len_in;
      end
      else if (busy_q && left_q == 16'h0000)
      begin
        busy_q       <= 1'b0;
        scan_end_out <= 1'b1;
      end
      else if (busy_q)
      begin
        left_q <= left_q - 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// ### test/acp_top_test.sv
`default_nettype none
module acp_top_test;
  import acp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic              sys_clk_in;
  logic              rst_n_in;
  acp_bus_req_t      bus_q;
  acp_instr_t        ins_q;
  logic              err_v_q;
  logic [CODE_W-1:0] err_c_q;
  logic              scan_end;
  logic [DATA_W-1:0] rdata;
  logic              scan_start, warn_led, alarm_led, halt, msg_clr;
  logic              err_flag, irq;
  logic [15:0]       scan_len_q;
  logic [15:0]       v;
  int                mismatches, compares, cyc, t_start, gap, n_starts, n0;

  acp_top u_acp_top (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .bus_in(bus_q),
    .bus_rdata_out(rdata), .instr_in(ins_q), .sys_err_valid_in(err_v_q),
    .sys_err_code_in(err_c_q), .scan_end_in(scan_end),
    .scan_start_out(scan_start), .warn_led_out(warn_led),
    .alarm_led_out(alarm_led), .halt_out(halt), .msg_clear_out(msg_clr),
    .error_flag_out(err_flag), .irq_out(irq));

  acp_scan_model u_acp_scan_model (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .scan_start_in(scan_start),
    .scan_len_in(scan_len_q), .scan_end_out(scan_end));

  initial
  begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Ceiling well above the roughly 40000 cycles the sequence needs
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 80000)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
    if (scan_start === 1'b1)
    begin
      gap      <= cyc - t_start;
      t_start  <= cyc;
      n_starts <= n_starts + 1;
    end
  end

  task automatic check(input string what, input logic [15:0] got, exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk_in);
    bus_q.wr <= 1'b0;
    @(negedge sys_clk_in);
  endtask

  task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk_in);
    bus_q.rd <= 1'b0;
    @(negedge sys_clk_in);
    d = rdata;
  endtask

  task automatic exec(input acp_kind_t k, input logic [7:0] d,
                      input logic [15:0] op, input logic ind, rng);
    @(posedge sys_clk_in);
    ins_q <= '{valid: 1'b1, kind: k, definer: d, operand: op,
               indirect: ind, pointer: op, in_range: rng};
    @(posedge sys_clk_in);
    ins_q.valid <= 1'b0;
    @(negedge sys_clk_in);
  endtask

  task automatic word_is(input logic [15:0] exp);
    bus_read(ADDR_ALARM_CODE, v);
    check("alarm_code_word", v, exp);
  endtask

  task automatic wait_start();
    int i;
    i = 0;
    @(posedge sys_clk_in);
    while (scan_start !== 1'b1 && i < 10000)
    begin
      @(posedge sys_clk_in);
      i = i + 1;
    end
    if (i >= 10000)
      mismatches = mismatches + 1;
    @(negedge sys_clk_in);
  endtask

  task automatic gap_in(input int lo, hi);
    wait_start();
    wait_start();
    check("scan_gap", 16'(gap >= lo && gap <= hi), 16'h0001);
  endtask

  initial
  begin
    mismatches = 0;
    compares = 0;
    cyc = 0;
    t_start = 0;
    gap = 0;
    n_starts = 0;
    rst_n_in = 1'b0;
    bus_q = '0;
    ins_q = '0;
    err_v_q = 1'b0;
    err_c_q = 8'h00;
    scan_len_q = 16'h0014;
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    bus_write(ADDR_ALARM_CODE, 16'hffff);
    word_is(16'h0000);
    bus_read(ADDR_INT_MASK, v);
    check("int_mask", v, 16'h0000);
    bus_read(ADDR_MIN_CYC, v);
    check("min_cycle", v, 16'h0000);
    bus_read(8'h80, v);
    check("unmapped", v, 16'h0000);
    // Fill the pending queue, a fourth code is dropped
    exec(ACP_KIND_FAL, 8'h12, 16'h0000, 1'b0, 1'b1);
    check("warn_led", 16'(warn_led), 16'h0001);
    word_is(16'h0512);
    @(posedge sys_clk_in);
    err_v_q <= 1'b1;
    err_c_q <= 8'h35;
    @(posedge sys_clk_in);
    err_v_q <= 1'b0;
    word_is(16'h0912);
    exec(ACP_KIND_FAL, 8'h44, 16'h0000, 1'b0, 1'b1);
    exec(ACP_KIND_FAL, 8'h55, 16'h0000, 1'b0, 1'b1);
    word_is(16'h0d12);
    bus_read(ADDR_INT_STAT, v);
    check("int_status", v, 16'h0025);
    check("irq_masked", 16'(irq), 16'h0000);
    bus_write(ADDR_INT_MASK, 16'h0004);
    check("irq", 16'(irq), 16'h0001);
    bus_write(ADDR_INT_STAT, 16'h0004);
    check("irq_cleared", 16'(irq), 16'h0000);
    bus_read(ADDR_INT_STAT, v);
    check("int_status_w1c", v, 16'h0021);
    exec(ACP_KIND_FAL, 8'h00, 16'h0000, 1'b0, 1'b1);
    check("msg_clear", 16'(msg_clr), 16'h0001);
    word_is(16'h0935);
    exec(ACP_KIND_FAL, 8'h00, 16'h0000, 1'b0, 1'b1);
    word_is(16'h0544);
    exec(ACP_KIND_FAL, 8'h00, 16'h0000, 1'b0, 1'b1);
    word_is(16'h0000);
    check("warn_off", 16'(warn_led), 16'h0000);
    // Bad definers post nothing
    exec(ACP_KIND_FAL, 8'h1a, 16'h0000, 1'b0, 1'b1);
    check("err_fal", 16'(err_flag), 16'h0001);
    exec(ACP_KIND_FALS, 8'h00, 16'h0000, 1'b0, 1'b1);
    check("err_fals", 16'(err_flag), 16'h0001);
    word_is(16'h0000);
    exec(ACP_KIND_FAL, 8'h00, 16'h0000, 1'b0, 1'b1);
    check("err_ok", 16'(err_flag), 16'h0000);
    // Severe alarm stops scans and instructions until console clear
    exec(ACP_KIND_FALS, 8'h77, 16'h0000, 1'b0, 1'b1);
    check("alarm_led", 16'(alarm_led), 16'h0001);
    check("halt", 16'(halt), 16'h0001);
    exec(ACP_KIND_FAL, 8'h12, 16'h0000, 1'b0, 1'b1);
    word_is(16'h0677);
    n0 = n_starts;
    repeat (200) @(posedge sys_clk_in);
    check("halted_starts", 16'(n_starts - n0), 16'h0000);
    bus_write(ADDR_CONTROL, 16'h0001);
    check("halt_clear", 16'(halt), 16'h0000);
    word_is(16'h0000);
    // Minimum cycle: top digit dropped, 3 units of 2000 cycles
    exec(ACP_KIND_SCAN, 8'h00, 16'h9003, 1'b0, 1'b1);
    gap_in(6000, 6004);
    // Over four whole units so the overrun shows at unit resolution
    scan_len_q <= 16'h2328;
    gap_in(9000, 9004);
    bus_read(ADDR_INT_STAT, v);
    check("overrun", v & 16'h0008, 16'h0008);
    scan_len_q <= 16'h0014;
    exec(ACP_KIND_SCAN, 8'h00, 16'h0001, 1'b1, 1'b0);
    check("err_range", 16'(err_flag), 16'h0001);
    exec(ACP_KIND_SCAN, 8'h00, 16'h00a1, 1'b1, 1'b1);
    check("err_bcd", 16'(err_flag), 16'h0001);
    exec(ACP_KIND_SCAN, 8'h00, 16'h0000, 1'b0, 1'b1);
    check("err_scan_ok", 16'(err_flag), 16'h0000);
    bus_write(ADDR_MIN_CYC, 16'h0002);
    bus_write(ADDR_MIN_CYC, 16'h00a0);
    bus_read(ADDR_MIN_CYC, v);
    check("min_cycle_rw", v, 16'h0002);
    gap_in(4000, 4004);
    print_verdict();
  end
endmodule
`default_nettype wire
